// File: src/scfi_core.sv
// Behaviour
// - act on last eight bits of frame
// - three opcode bits, five data bits
// - bit count not nonzero multiple of eight: error
// - first response after reset is status 0
// - query opcode selects status 0 to 3
// - mask commands load selected group nibble, return status 0
// - mask one enables flag; masks reset ones
// - opcode 010 sets mode bits, returns status 0
// - clear command clears selected group latches
// - opcode 100 sets deadtime, returns status 0
// - most commands return status register 0
// - pending interrupt drives interrupt pin high
// - faults latch until matching clear command
// - present unmasked fault keeps interrupt high
// - status shows faults since last clear
// - status query changes no latch or mask
// - clear acts only on error-free frame
// - fault set mid-frame survives its clear
// - latches clear at chip select rising edge
// - mask bits gate the listed fault sources
// - writes after lock refused, raise write error
// - calibration pulse counted, divided by sixteen
// - deadtime resets to 255 cycles
`timescale 1ns/100ps
module scfi_core
	import scfi_pkg::*;
#(
	parameter int CAL_W = 13
)(
	// clock and reset
	input  wire logic         clk,
	input  wire logic         nrst,
	// serial port pins
	input  wire logic         csN,
	input  wire logic         sclk,
	input  wire logic         si,
	output logic              so,
	output logic              soEn,
	// fault sources and other status
	input  wire scfi_fault_s  faults,
	input  wire scfi_status_s statusExt,
	// interrupt and configuration
	output logic              intOut,
	output scfi_mode_s        mode,
	output logic [7:0]        deadtime
);

	////////////////////////////////////////////////////////////////////////////
	logic [2:0]  pinS;
	logic        csS, sclkS, siS;
	logic        csPrev_q, sclkPrev_q, siPrev_q;
	logic        csFall, csRise, sclkRise, sclkFall;

	// select enters inverted so a cleared stage reads as deselected, no false fall
	scfi_sync #(
		.WIDTH(3)
	) u_sync (
		.clk    (clk),
		.nrst   (nrst),
		.asyncIn({~csN, sclk, si}),
		.syncOut(pinS)
	);

	assign {csS, sclkS, siS} = pinS ^ 3'b100;

	always_ff @(posedge clk)
	begin
		if (!nrst)
		begin
			csPrev_q   <= 1'b1;
			sclkPrev_q <= 1'b0;
			siPrev_q   <= 1'b0;
		end
		else
		begin
			csPrev_q   <= csS;
			sclkPrev_q <= sclkS;
			siPrev_q   <= siS;
		end
	end

	assign csFall   = csPrev_q & ~csS;
	assign csRise   = ~csPrev_q & csS;
	assign sclkRise = ~csS & ~sclkPrev_q & sclkS;
	assign sclkFall = ~csS & sclkPrev_q & ~sclkS;

	////////////////////////////////////////////////////////////////////////////
	scfi_state_e state_q;
	logic        calArm_q;
	logic [7:0]  rx_q;
	logic [2:0]  bitCnt_q;
	logic        anyBit_q;
	logic        calNoise_q;
	logic [CAL_W-1:0] calCnt_q;

	// state: a calibration pulse follows an armed deadtime command
	always_ff @(posedge clk)
	begin
		if (!nrst)
			state_q <= ST_IDLE;
		else
		begin
			case (state_q)
				ST_IDLE:  if (csFall) state_q <= calArm_q ? ST_CALIB : ST_SHIFT;
				ST_SHIFT: if (csRise) state_q <= ST_IDLE;
				ST_CALIB: if (csRise) state_q <= ST_IDLE;
				default:  state_q <= ST_IDLE;
			endcase
		end
	end

	// receive shift: only the last eight bits survive
	always_ff @(posedge clk)
	begin
		if (!nrst)
		begin
			rx_q     <= '0;
			bitCnt_q <= '0;
			anyBit_q <= 1'b0;
		end
		else if (csFall)
		begin
			bitCnt_q <= '0;
			anyBit_q <= 1'b0;
		end
		else if (state_q == ST_SHIFT && sclkRise)
		begin
			rx_q     <= {rx_q[6:0], siS};
			bitCnt_q <= bitCnt_q + 3'h1;
			anyBit_q <= 1'b1;
		end
	end

	// calibration: count clk cycles while chip select stays low
	always_ff @(posedge clk)
	begin
		if (!nrst)
		begin
			calCnt_q   <= '0;
			calNoise_q <= 1'b0;
		end
		else if (csFall)
		begin
			calCnt_q   <= '0;
			calNoise_q <= 1'b0;
		end
		else if (state_q == ST_CALIB)
		begin
			if (calCnt_q != '1)
				calCnt_q <= calCnt_q + CAL_W'(1);
			if (sclkS != sclkPrev_q || siS != siPrev_q)
				calNoise_q <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	logic       frameEnd, frameBad, cmdOk;
	logic [2:0] opcode;
	logic [4:0] cmdData;
	logic       cfgWrite, wrRefused;

	assign frameEnd = csRise && state_q == ST_SHIFT;
	assign frameBad = !anyBit_q || bitCnt_q != 3'h0;
	assign cmdOk    = frameEnd && !frameBad;
	assign opcode   = rx_q[OPC_MSB:OPC_LSB];
	assign cmdData  = rx_q[4:0];
	// anything that would change mask, mode or deadtime
	assign cfgWrite  = cmdOk && (opcode == OP_MASK || opcode == OP_MODE || opcode == OP_DTIME);
	assign wrRefused = cfgWrite && mode.lock;

	////////////////////////////////////////////////////////////////////////////
	logic [3:0] maskLow_q, maskHigh_q;
	logic [7:0] deadtimeCal;

	always_ff @(posedge clk)
	begin
		if (!nrst)
		begin
			maskLow_q  <= MASK_RST;
			maskHigh_q <= MASK_RST;
		end
		else if (cmdOk && opcode == OP_MASK && !mode.lock)
		begin
			if (cmdData[GROUP_BIT])
				maskHigh_q <= cmdData[3:0];
			else
				maskLow_q  <= cmdData[3:0];
		end
	end

	// lock can be set together with the mode, cleared only by reset
	always_ff @(posedge clk)
	begin
		if (!nrst)
			mode <= '0;
		else if (cmdOk && opcode == OP_MODE && !mode.lock)
		begin
			mode.desatIgnore           <= cmdData[DESAT_BIT];
			mode.simultaneousDriveMode <= cmdData[SIMDRV_BIT];
			mode.lock                  <= cmdData[LOCK_BIT];
		end
	end

	// pulse is sixteen deadtimes; divide and saturate
	assign deadtimeCal = (calCnt_q[CAL_W-1:CAL_DIV_SHIFT] > (CAL_W-CAL_DIV_SHIFT)'(DTIME_MAX)) ? DTIME_MAX
	                   : 8'(calCnt_q[CAL_W-1:CAL_DIV_SHIFT]);

	always_ff @(posedge clk)
	begin
		if (!nrst)
		begin
			deadtime <= DTIME_RST;
			calArm_q <= 1'b0;
		end
		else if (csRise && state_q == ST_CALIB)
		begin
			deadtime <= deadtimeCal;
			calArm_q <= 1'b0;
		end
		else if (cmdOk && opcode == OP_DTIME && !mode.lock)
		begin
			if (cmdData[DTCAL_BIT])
				calArm_q <= 1'b1;
			else
				deadtime <= '0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	logic [7:0] latch_q, snap_q, faultEvt, clrBits;
	logic       frmEvt;

	// a noisy calibration pulse still calibrates but is reported
	assign frmEvt = (frameEnd && frameBad) || (csRise && state_q == ST_CALIB && calNoise_q);

	assign faultEvt = {1'b0, wrRefused, frmEvt, faults.phase, faults.overCurrent,
	                   faults.vlsUnder, faults.desat, faults.overTemp};

	// only bits reported at frame start may be cleared
	assign clrBits = (cmdOk && opcode == OP_CLEAR) ?
	                 (cmdData[GROUP_BIT] ? {cmdData[3:0], 4'h0} : {4'h0, cmdData[3:0]}) & snap_q
	                 : 8'h00;

	// set beats clear, so a standing fault survives its clear
	always_ff @(posedge clk)
	begin
		if (!nrst)
			latch_q <= LATCH_RST;
		else
			latch_q <= (latch_q & ~clrBits) | faultEvt;
	end

	always_ff @(posedge clk)
	begin
		if (!nrst)
			snap_q <= '0;
		else if (csFall)
			snap_q <= latch_q;
	end

	always_ff @(posedge clk)
	begin
		if (!nrst)
			intOut <= 1'b0;
		else
			intOut <= |(latch_q & {maskHigh_q, maskLow_q});
	end

	////////////////////////////////////////////////////////////////////////////
	logic [1:0] respSel_q;
	logic [7:0] tx_q, respWord;

	always_ff @(posedge clk)
	begin
		if (!nrst)
			respSel_q <= RSEL_RST;
		else if (cmdOk)
			respSel_q <= (opcode == OP_NULL) ? cmdData[1:0] : RSEL_RST;
	end

	always_comb
	begin
		case (respSel_q)
			2'h1:    respWord = statusExt.status1;
			2'h2:    respWord = statusExt.status2;
			2'h3:    respWord = statusExt.status3;
			default: respWord = latch_q;
		endcase
	end

	// msb first; trailing bits pass the input on for daisy chains
	always_ff @(posedge clk)
	begin
		if (!nrst)
		begin
			tx_q <= '0;
			so   <= 1'b0;
			soEn <= 1'b0;
		end
		else
		begin
			soEn <= ~csS;
			if (csFall)
			begin
				tx_q <= {respWord[6:0], 1'b0};
				so   <= respWord[7];
			end
			else if (sclkFall && state_q == ST_SHIFT)
			begin
				so   <= tx_q[7];
				tx_q <= {tx_q[6:0], siS};
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);

	a_mask_reset: assert property ($rose(nrst) |-> maskLow_q == MASK_RST && maskHigh_q == MASK_RST)
		else $error("masks not all ones after reset");
	a_dtime_reset: assert property ($rose(nrst) |-> deadtime == DTIME_RST)
		else $error("deadtime not maximum after reset");
	a_resp_first: assert property ($rose(nrst) |-> respSel_q == RSEL_RST && latch_q[FLT_RESET])
		else $error("first response not status zero");
	a_int_level: assert property (faults.overTemp && maskLow_q[0] ##1 maskLow_q[0] |=> intOut)
		else $error("interrupt low while unmasked fault latched");
	a_fault_hold: assert property (faults.overTemp |=> latch_q[FLT_OVERTEMP] ##1
		(latch_q[FLT_OVERTEMP] || (!$past(faults.overTemp) && $past(clrBits[FLT_OVERTEMP]))))
		else $error("present fault not held in latch");
	a_bad_frame: assert property (frameEnd && frameBad |=>
		latch_q[FLT_FRAMING] && (latch_q & $past(latch_q)) == $past(latch_q))
		else $error("bad frame cleared latch or missed error");
	a_null_keep: assert property (cmdOk && opcode == OP_NULL |=>
		$stable({maskHigh_q, maskLow_q}) && (latch_q & $past(latch_q)) == $past(latch_q))
		else $error("status query changed state");
	a_lock_refuse: assert property (cfgWrite && mode.lock |=>
		$stable({maskHigh_q, maskLow_q}) && $stable(deadtime) && latch_q[FLT_WRLOCK])
		else $error("write after lock not refused");
	a_keep_new: assert property (cmdOk && opcode == OP_CLEAR && !cmdData[GROUP_BIT] && cmdData[0]
		&& !snap_q[FLT_OVERTEMP] && latch_q[FLT_OVERTEMP] |=> latch_q[FLT_OVERTEMP])
		else $error("unreported fault was cleared");
	a_clear_works: assert property (cmdOk && opcode == OP_CLEAR && !cmdData[GROUP_BIT] && cmdData[1]
		&& snap_q[FLT_DESAT] && !faults.desat |=> !latch_q[FLT_DESAT])
		else $error("clear command did not clear latch");

	c_good_frame: cover property (cmdOk);
	c_calib_done: cover property (csRise && state_q == ST_CALIB);
	c_int_rise: cover property ($rose(intOut));
	c_lock_set: cover property ($rose(mode.lock));

endmodule // scfi_core

// File: src/scfi_pkg.sv
package scfi_pkg;

	// command opcodes, top three bits of the word
	localparam logic [2:0] OP_NULL  = 3'h0;
	localparam logic [2:0] OP_MASK  = 3'h1;
	localparam logic [2:0] OP_MODE  = 3'h2;
	localparam logic [2:0] OP_CLEAR = 3'h3;
	localparam logic [2:0] OP_DTIME = 3'h4;

	// word layout
	localparam int WORD_BITS   = 8;
	localparam int OPC_MSB     = 7;
	localparam int OPC_LSB     = 5;
	localparam int GROUP_BIT   = 4;
	localparam int DESAT_BIT   = 3;
	localparam int SIMDRV_BIT  = 1;
	localparam int LOCK_BIT    = 0;
	localparam int DTCAL_BIT   = 0;

	// fault latch / status register 0 bit positions
	localparam int FLT_OVERTEMP = 0;
	localparam int FLT_DESAT    = 1;
	localparam int FLT_VLSUNDER = 2;
	localparam int FLT_OVERCUR  = 3;
	localparam int FLT_PHASE    = 4;
	localparam int FLT_FRAMING  = 5;
	localparam int FLT_WRLOCK   = 6;
	localparam int FLT_RESET    = 7;

	// values after reset, and the deadtime saturation limit
	localparam logic [7:0] LATCH_RST = 8'h80;
	localparam logic [3:0] MASK_RST  = 4'hf;
	localparam logic [7:0] DTIME_RST = 8'hff;
	localparam logic [7:0] DTIME_MAX = 8'hff;
	localparam logic [1:0] RSEL_RST  = 2'h0;

	// calibration pulse is two to this power deadtimes long (shift of 4, so 16)
	localparam int CAL_DIV_SHIFT = 4;

	typedef enum logic [2:0] {
		ST_IDLE  = 3'b001,
		ST_SHIFT = 3'b010,
		ST_CALIB = 3'b100
	} scfi_state_e;

	typedef struct packed {
		logic phase;
		logic overCurrent;
		logic vlsUnder;
		logic desat;
		logic overTemp;
	} scfi_fault_s;

	typedef struct packed {
		logic desatIgnore;
		logic simultaneousDriveMode;
		logic lock;
	} scfi_mode_s;

	typedef struct packed {
		logic [7:0] status3;
		logic [7:0] status2;
		logic [7:0] status1;
	} scfi_status_s;

endpackage

// File: src/scfi_sync.sv
`timescale 1ns/100ps
module scfi_sync
	import scfi_pkg::*;
#(
	parameter int WIDTH = 1
)(
	// clock and reset
	input  wire logic             clk,
	input  wire logic             nrst,
	// pins in, synchronised out
	input  wire logic [WIDTH-1:0] asyncIn,
	output logic      [WIDTH-1:0] syncOut
);

	logic [WIDTH-1:0] meta_q;

	// the first stage feeds only the second
	always_ff @(posedge clk)
	begin
		if (!nrst)
		begin
			meta_q  <= '0;
			syncOut <= '0;
		end
		else
		begin
			meta_q  <= asyncIn;
			syncOut <= meta_q;
		end
	end

endmodule // scfi_sync

// File: verif/scfi_host.sv
`timescale 1ns/100ps
module scfi_host (
	// clock
	input  wire logic clk,
	// serial port
	output logic      csN,
	output logic      sclk,
	output logic      si,
	input  wire logic so,
	input  wire logic soEn
);

	// idle levels follow the pin bias: select high, clock and data low
	initial
	begin
		csN = 1'b1;
		sclk = 1'b0;
		si = 1'b0;
	end

	////////////////////////////////////////////////////////////////
	// half periods of 4 clk keep the synchronised edges apart
	task automatic xfer(input int n, input logic [31:0] d, output logic [31:0] r);
		r = '0;
		@(negedge clk);
		csN = 1'b0;
		repeat (6) @(negedge clk);
		for (int i = n - 1; i >= 0; i--)
		begin
			si = d[i];
			repeat (4) @(negedge clk);
			sclk = 1'b1;
			r[i] = so & soEn;
			repeat (4) @(negedge clk);
			sclk = 1'b0;
		end
		si = 1'b0;
		repeat (4) @(negedge clk);
		csN = 1'b1;
		repeat (10) @(negedge clk);
	endtask

	// select low pulse only, no clock or data activity
	task automatic cal(input int n);
		@(negedge clk);
		csN = 1'b0;
		repeat (n) @(negedge clk);
		csN = 1'b1;
		repeat (10) @(negedge clk);
	endtask

endmodule // scfi_host

// File: verif/tb.sv
`timescale 1ns/100ps
module tb;
	import scfi_pkg::*;

	logic         clk;
	logic         nrst;
	logic         csN;
	logic         sclk;
	logic         si;
	logic         so;
	logic         soEn;
	logic         intOut;
	logic [4:0]   flt;
	scfi_status_s ext;
	scfi_mode_s   mode;
	logic [7:0]   deadtime;
	logic [31:0]  r;
	int           fail_count;
	int           n_checks;
	int           k;

	scfi_core scfi_core_inst (.clk(clk), .nrst(nrst), .csN(csN), .sclk(sclk), .si(si), .so(so),
		.soEn(soEn), .faults(scfi_fault_s'(flt)), .statusExt(ext), .intOut(intOut), .mode(mode),
		.deadtime(deadtime));

	scfi_host scfi_host_inst (.clk(clk), .csN(csN), .sclk(sclk), .si(si), .so(so), .soEn(soEn));

	////////////////////////////////////////////////////////////////
	task check_word(input string nm, input logic [7:0] e, input logic [7:0] g);
		n_checks++;
		if (g !== e)
		begin
			fail_count++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask

	task check_flag(input string nm, input logic e, input logic g);
		check_word(nm, {7'h0, e}, {7'h0, g});
	endtask

	task x(input logic [7:0] c);
		scfi_host_inst.xfer(8, {24'h0, c}, r);
	endtask

	// a null frame answers with the latches
	task rd(input logic [7:0] e);
		x(8'h00);
		check_word("status0", e, r[7:0]);
	endtask

	task pulse(input int b);
		@(negedge clk);
		flt[b] = 1'b1;
		repeat (2) @(negedge clk);
		flt[b] = 1'b0;
		repeat (6) @(negedge clk);
	endtask

	function automatic logic [7:0] dt_exp(input int n);
		return (n >> 4) > 255 ? 8'hff : 8'(n >> 4);
	endfunction

	task report_and_stop;
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////
	initial
	begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	initial
	begin
		repeat (20000) @(posedge clk);
		fail_count++;
		$display("ERROR watchdog expected end seen hang");
		report_and_stop;
	end

	initial
	begin
		nrst = 1'b0;
		flt = 5'h0;
		ext = '0;
		fail_count = 0;
		n_checks = 0;
		void'($urandom(66733));
		repeat (8) @(negedge clk);
		nrst = 1'b1;
		repeat (4) @(negedge clk);
		x(8'h00);
		check_word("first", 8'h80, r[7:0]);
		check_flag("int", 1'b1, intOut);
		check_word("dtime", 8'hff, deadtime);
		check_word("mode", 8'h00, {5'h0, mode});
		check_flag("soEn", 1'b0, soEn);
		x(8'h78);
		check_word("resp", 8'h80, r[7:0]);
		check_flag("int", 1'b0, intOut);
		rd(8'h00);
		$display("test reset done");
		ext = scfi_status_s'(24'($urandom));
		for (int s = 1; s < 4; s++)
		begin
			x(8'(s));
			x(8'h00);
			check_word("statusN", ext[8*s-1 -: 8], r[7:0]);
		end
		pulse(FLT_OVERTEMP);
		check_flag("int", 1'b1, intOut);
		rd(8'h01);
		rd(8'h01);
		flt[FLT_OVERCUR] = 1'b1;
		repeat (4) @(negedge clk);
		x(8'h68);
		rd(8'h09);
		x(8'h61);
		rd(8'h08);
		check_flag("int", 1'b1, intOut);
		flt[FLT_OVERCUR] = 1'b0;
		x(8'h68);
		rd(8'h00);
		check_flag("int", 1'b0, intOut);
		fork
			x(8'h61);
			begin
				repeat (30) @(negedge clk);
				flt[FLT_OVERTEMP] = 1'b1;
				@(negedge clk);
				flt[FLT_OVERTEMP] = 1'b0;
			end
		join
		rd(8'h01);
		x(8'h61);
		pulse(FLT_DESAT);
		pulse(FLT_VLSUNDER);
		pulse(FLT_PHASE);
		rd(8'h16);
		x(8'h66);
		x(8'h71);
		rd(8'h00);
		$display("test latch done");
		x(8'h2e);
		pulse(FLT_OVERTEMP);
		check_flag("int", 1'b0, intOut);
		rd(8'h01);
		x(8'h61);
		x(8'h2f);
		x(8'h3d);
		scfi_host_inst.xfer(7, 32'h0, r);
		check_flag("int", 1'b0, intOut);
		rd(8'h20);
		x(8'h3f);
		check_flag("int", 1'b1, intOut);
		scfi_host_inst.xfer(9, 32'h072, r);
		rd(8'h20);
		scfi_host_inst.xfer(16, 32'ha572, r);
		check_word("daisy", 8'h20, r[15:8]);
		rd(8'h00);
		$display("test frame done");
		for (int o = 5; o < 8; o++)
		begin
			x({3'(o), 5'h1f});
			check_word("resp", 8'h00, r[7:0]);
		end
		check_word("mode", 8'h00, {5'h0, mode});
		check_word("dtime", 8'hff, deadtime);
		k = 16 * (1 + int'($urandom % 200)) + 4;
		x(8'h81);
		check_word("resp", 8'h00, r[7:0]);
		scfi_host_inst.cal(k);
		check_word("dtime", dt_exp(k), deadtime);
		x(8'h80);
		check_word("dtime", 8'h00, deadtime);
		$display("test deadtime done");
		x(8'h4a);
		check_word("mode", 8'h06, {5'h0, mode});
		x(8'h41);
		x(8'h4a);
		check_word("mode", 8'h01, {5'h0, mode});
		rd(8'h40);
		check_flag("int", 1'b1, intOut);
		$display("test lock done");
		@(negedge clk);
		nrst = 1'b0;
		repeat (8) @(negedge clk);
		nrst = 1'b1;
		repeat (4) @(negedge clk);
		check_word("mode", 8'h00, {5'h0, mode});
		check_word("dtime", 8'hff, deadtime);
		check_flag("int", 1'b1, intOut);
		rd(8'h80);
		$display("test rerun done");
		report_and_stop;
	end

endmodule // tb
